// ==== core/vpf_consts.svh ====
// Constants of the packet virtual FIFO port: widths, thresholds and timing counts
`ifndef VPF_CONSTS_SVH
`define VPF_CONSTS_SVH
`define VPF_DATA_W 64
`define VPF_KEEP_W 8
`define VPF_LEN_W 16
`define VPF_ADDR_W 12
`define VPF_FILL_W 13
`define VPF_MEM_WORDS 4096
`define VPF_BURST_W 9
`define VPF_FIFO_DEPTH 11'h400
`define VPF_FIFO_CNT_W 11
`define VPF_FIFO_ADDR_W 10
`define VPF_IN_ROOM_MAX 11'h3fc
`define VPF_HDR_MARK 16'ha5c3
`define VPF_HDR_MARK_LSB 48
`define VPF_KEEP_ALL 8'hff
`define VPF_CLK_PERIOD_NS 4
`define VPF_FLUSH_TIME_NS 1000
`define VPF_FLUSH_CYCLES (`VPF_FLUSH_TIME_NS / `VPF_CLK_PERIOD_NS)
`define VPF_TRAIN_TIME_NS 4000
`define VPF_TRAIN_CYCLES (`VPF_TRAIN_TIME_NS / `VPF_CLK_PERIOD_NS)
`define VPF_SYNC_W 91
`define VPF_HELD_W 83
`endif

// ==== core/vpf_pkg.sv ====
// Types shared by the packet virtual FIFO port files
`include "vpf_consts.svh"
package vpf_pkg;
	typedef logic [`VPF_DATA_W-1:0] vpf_word_type;
	typedef enum {MOVE_IDLE, MOVE_RUN} vpf_mover_type;
endpackage: vpf_pkg

// ==== core/vpf_port_top.sv ====
// One port of the packet virtual FIFO: ingress and egress streams around a circular word store
//
// Behaviour
// - Egress byte enables stay all set except on the last beat of a packet.
// - Egress length sideband carries the packet length with the first beat.
// - Ingress signals are sampled on the writer's own ingress clock.
// - Egress signals are driven and sampled on the reader's own egress clock.
// - Ingress and egress sides each have their own independent active-low reset.
// - Stored words stay within the base and top bounds, used circularly.
// - Write bursts toward memory are capped at the ingress burst length.
// - Read bursts from memory are capped at the egress burst length.
// - Training-finished flag rises once memory calibration completes.
// - Drained flag is set when store and both preview FIFOs are empty.
// - Shim reset resets the memory movers, not the memory core.
// - Core reset input resets the memory core; it comes from card reset.
// - Block outputs a memory user clock and its accompanying user reset.
// - Egress beat moves only when valid and ready are both high.
// - A control word precedes each stored packet and is stripped on egress.
// - Burst length is a maximum; a timeout issues a shorter write burst.
// - Packets from 64 bytes up to 32 kilobytes are handled.
// - Ingress and egress preview buffers are 64 bits by 1024 entries.
`timescale 1ns/1ns
`include "vpf_consts.svh"
module vpf_port_top (
	input wire logic clock, // Core clock, 250 MHz
	input wire logic reset, // Synchronous reset, active high
	input wire logic ingressClock, // Writer's stream clock
	input wire logic ingressValid, // Writer beat valid
	input wire logic ingressLast, // Writer end of packet
	input wire vpf_pkg::vpf_word_type ingressData, // Writer beat data
	input wire logic [`VPF_LEN_W-1:0] ingressLength, // Packet length in bytes
	output logic ingressReady, // Room for a beat
	input wire logic ingress_port_reset_low, // Ingress side reset, active low
	input wire logic egressClock, // Reader's stream clock
	input wire logic egressReady, // Reader takes a beat
	output logic egressValid, // Beat valid
	output logic egressLast, // End of packet
	output vpf_pkg::vpf_word_type egressData, // Beat data
	output logic [`VPF_KEEP_W-1:0] egressKeep, // Byte enables
	output logic [`VPF_LEN_W-1:0] egressLength, // Packet length in bytes
	input wire logic egress_port_reset_low, // Egress side reset, active low
	input wire logic [`VPF_ADDR_W-1:0] region_base_bound, // First word of the store region
	input wire logic [`VPF_ADDR_W-1:0] region_top_bound, // Last word of the store region
	input wire logic [`VPF_BURST_W-1:0] ingress_burst_length, // Write burst cap
	input wire logic [`VPF_BURST_W-1:0] egress_burst_length, // Read burst cap
	input wire logic reference_clock_pos, // Reference clock, true leg
	input wire logic reference_clock_neg, // Reference clock, inverted leg
	input wire logic memory_core_reset, // Memory core reset from card reset
	output logic memory_user_clock, // Memory user clock
	output logic memory_user_reset, // Memory user reset
	output logic memory_training_finished, // Calibration done
	output logic per_port_drained_flag, // Port holds no data
	input wire logic fabric_shim_reset_low // Mover reset, active low
);
	import vpf_pkg::*;

	// ==========================================================
	// Input synchronisers
	logic [`VPF_SYNC_W-1:0] syncA_q;
	logic [`VPF_SYNC_W-1:0] syncB_q;
	logic [`VPF_HELD_W-1:0] held_q;
	logic refPosS, refNegS;
	logic inClkS, inValidS, inLastS, inResetLowS, outClkS, outReadyS, outResetLowS;
	logic inValidN, inLastN, outReadyN;
	logic refS, coreResetS, shimResetLowS;
	vpf_word_type inDataS, inDataN;
	logic [`VPF_LEN_W-1:0] inLenS, inLenN;
	assign {inClkS, inValidN, inLastN, inDataN, inLenN, inResetLowS, outClkS, outReadyN, outResetLowS, refPosS,
		refNegS, coreResetS, shimResetLowS} = syncB_q;
	assign {inValidS, inLastS, inDataS, inLenS, outReadyS} = held_q;
	assign refS = refPosS & ~refNegS;

	// Stream lines are used one sample older than the found edge: partners change them just after their edge
	always_ff @(posedge clock) begin
		if (reset) begin
			syncA_q <= '0;
			syncB_q <= '0;
			held_q <= '0;
		end else begin
			syncA_q <= {ingressClock, ingressValid, ingressLast, ingressData, ingressLength, ingress_port_reset_low,
				egressClock, egressReady, egress_port_reset_low, reference_clock_pos, reference_clock_neg,
				memory_core_reset, fabric_shim_reset_low};
			syncB_q <= syncA_q;
			held_q <= {inValidN, inLastN, inDataN, inLenN, outReadyN};
		end
	end

	// ==========================================================
	// Edges and resets
	logic inClkPrev_q, outClkPrev_q;
	logic inEdge, outEdge, inRst, outRst, coreRst, shimRst;
	assign inEdge = inClkS & ~inClkPrev_q;
	assign outEdge = outClkS & ~outClkPrev_q;
	assign inRst = reset | ~inResetLowS;
	assign outRst = reset | ~outResetLowS;
	assign coreRst = reset | coreResetS;
	assign shimRst = reset | ~shimResetLowS;

	// Held high in port reset, so a clock already high at release is not taken for an edge
	always_ff @(posedge clock) begin
		inClkPrev_q <= inRst ? 1'b1 : inClkS;
		outClkPrev_q <= outRst ? 1'b1 : outClkS;
	end

	// ==========================================================
	// Calibration and memory user clock
	logic [9:0] trainCount_q;
	logic trainDone_q, userClk_q, userRst_q, trainOut_q;
	always_ff @(posedge clock) begin
		if (coreRst) begin
			trainCount_q <= 10'h000;
			trainDone_q <= 1'b0;
		end else if (trainCount_q == 10'(`VPF_TRAIN_CYCLES - 1)) begin
			trainDone_q <= 1'b1;
		end else begin
			trainCount_q <= trainCount_q + 10'h001;
		end
	end

	// Limitation: the user clock is the reference as seen by the core clock, so it carries sampling jitter
	always_ff @(posedge clock) begin
		userClk_q <= reset ? 1'b0 : refS;
		userRst_q <= reset ? 1'b1 : (coreRst | ~trainDone_q);
		trainOut_q <= reset ? 1'b0 : trainDone_q;
	end
	assign memory_user_clock = userClk_q;
	assign memory_user_reset = userRst_q;
	assign memory_training_finished = trainOut_q;

	// ==========================================================
	// Ingress packer: control word first, then the beat one cycle later
	logic inReady_q, inPkt_q, pendValid_q;
	vpf_word_type pendData_q, hdrWord, inFifoData, inHead;
	logic accept, pushHdr, inFifoValid, inHeadValid, inHeadReady;
	logic [`VPF_FIFO_CNT_W-1:0] inCount;
	assign accept = inEdge && inValidS && inReady_q;
	assign pushHdr = accept && !inPkt_q;
	assign hdrWord = {`VPF_HDR_MARK, 32'h0000_0000, inLenS};
	assign inFifoValid = pendValid_q | accept;
	assign inFifoData = pendValid_q ? pendData_q : (pushHdr ? hdrWord : inDataS);

	// Ready changes only at writer edges; room for four words means a push is never refused
	always_ff @(posedge clock) begin
		if (inRst) begin
			inReady_q <= 1'b0;
			inPkt_q <= 1'b0;
			pendValid_q <= 1'b0;
			pendData_q <= '0;
		end else begin
			if (inEdge) inReady_q <= inCount <= `VPF_IN_ROOM_MAX;
			if (accept) inPkt_q <= !inLastS;
			pendValid_q <= pushHdr;
			if (pushHdr) pendData_q <= inDataS;
		end
	end
	assign ingressReady = inReady_q;

	vpf_preview_fifo ingressBuffer (
		.clock(clock),
		.reset(inRst),
		.inData(inFifoData),
		.inValid(inFifoValid),
		.inReady(),
		.outData(inHead),
		.outValid(inHeadValid),
		.outReady(inHeadReady),
		.count(inCount)
	);

	// ==========================================================
	// Circular word store and the two burst movers
	vpf_word_type region [0:`VPF_MEM_WORDS-1];
	logic [`VPF_ADDR_W-1:0] wrPtr_q, rdPtr_q;
	logic [`VPF_FILL_W-1:0] fill_q, regionSize;
	logic [7:0] wTimer_q;
	logic [`VPF_BURST_W-1:0] wBeats_q, rBeats_q;
	vpf_mover_type wState_q, rState_q;
	logic memSpace, memHas, wStart, rStart, wGo, rGo, egInReady;
	logic [`VPF_FIFO_CNT_W-1:0] egCount;
	assign regionSize = {1'b0, region_top_bound - region_base_bound} + 13'h0001;
	assign memSpace = fill_q < regionSize;
	assign memHas = fill_q != 13'h0000;
	assign wStart = trainDone_q && (inCount >= {2'b00, ingress_burst_length} ||
		(inHeadValid && wTimer_q == 8'(`VPF_FLUSH_CYCLES - 1)));
	assign rStart = trainDone_q && memHas && (egCount <= `VPF_FIFO_DEPTH - {2'b00, egress_burst_length});
	assign wGo = wState_q == MOVE_RUN && inHeadValid && memSpace && wBeats_q != ingress_burst_length;
	assign rGo = rState_q == MOVE_RUN && memHas && egInReady && rBeats_q != egress_burst_length;
	assign inHeadReady = wGo;

	// Store writes; words keep their order so packets leave as they came
	always_ff @(posedge clock) begin
		if (wGo) region[wrPtr_q] <= inHead;
	end

	// Pointers wrap from the top bound back to the base bound
	always_ff @(posedge clock) begin
		if (coreRst) begin
			wrPtr_q <= region_base_bound;
			rdPtr_q <= region_base_bound;
			fill_q <= 13'h0000;
		end else begin
			if (wGo) wrPtr_q <= (wrPtr_q == region_top_bound) ? region_base_bound : wrPtr_q + 12'h001;
			if (rGo) rdPtr_q <= (rdPtr_q == region_top_bound) ? region_base_bound : rdPtr_q + 12'h001;
			fill_q <= fill_q + {12'h000, wGo} - {12'h000, rGo};
		end
	end

	// Movers end a burst early when their source runs dry, which keeps light traffic moving
	always_ff @(posedge clock) begin
		if (shimRst) begin
			wState_q <= MOVE_IDLE;
			rState_q <= MOVE_IDLE;
			wBeats_q <= 9'h000;
			rBeats_q <= 9'h000;
			wTimer_q <= 8'h00;
		end else begin
			wTimer_q <= (wState_q == MOVE_IDLE && inHeadValid && !wStart) ? wTimer_q + 8'h01 : 8'h00;
			case (wState_q)
				MOVE_IDLE: if (wStart) wState_q <= MOVE_RUN;
				MOVE_RUN: if (!wGo) wState_q <= MOVE_IDLE;
				default: wState_q <= MOVE_IDLE;
			endcase
			wBeats_q <= (wState_q == MOVE_RUN) ? wBeats_q + {8'h00, wGo} : 9'h000;
			case (rState_q)
				MOVE_IDLE: if (rStart) rState_q <= MOVE_RUN;
				MOVE_RUN: if (!rGo) rState_q <= MOVE_IDLE;
				default: rState_q <= MOVE_IDLE;
			endcase
			rBeats_q <= (rState_q == MOVE_RUN) ? rBeats_q + {8'h00, rGo} : 9'h000;
		end
	end

	// ==========================================================
	// Egress unpacker: strip the control word, rebuild last and byte enables
	vpf_word_type egHead;
	logic egHas, hdrPop, dataPop, load, lastBeat, atHdr_q, first_q, outFirst_q;
	logic [`VPF_LEN_W-1:0] remain_q, curLen_q;
	logic [`VPF_KEEP_W-1:0] lastKeep;
	logic outValid_q, outLast_q;
	vpf_word_type outData_q;
	logic [`VPF_KEEP_W-1:0] outKeep_q;
	logic [`VPF_LEN_W-1:0] outLen_q;
	// Header waits off reader edges, so a taken beat is never left standing
	assign hdrPop = atHdr_q && egHas && !outEdge;
	assign load = outEdge && (!outValid_q || outReadyS);
	assign dataPop = load && !atHdr_q && egHas;
	assign lastBeat = remain_q <= 16'h0008;
	assign lastKeep = `VPF_KEEP_ALL >> (4'h8 - remain_q[3:0]);

	vpf_preview_fifo egressBuffer (
		.clock(clock),
		.reset(outRst),
		.inData(region[rdPtr_q]),
		.inValid(rGo),
		.inReady(egInReady),
		.outData(egHead),
		.outValid(egHas),
		.outReady(hdrPop | dataPop),
		.count(egCount)
	);

	// Outputs move only at reader edges, so they hold steady for a whole reader period
	always_ff @(posedge clock) begin
		if (outRst) begin
			atHdr_q <= 1'b1;
			first_q <= 1'b0;
			outFirst_q <= 1'b0;
			remain_q <= 16'h0000;
			curLen_q <= 16'h0000;
			outValid_q <= 1'b0;
			outLast_q <= 1'b0;
			outData_q <= '0;
			outKeep_q <= 8'h00;
			outLen_q <= 16'h0000;
		end else if (hdrPop) begin
			atHdr_q <= 1'b0;
			first_q <= 1'b1;
			remain_q <= egHead[`VPF_LEN_W-1:0];
			curLen_q <= egHead[`VPF_LEN_W-1:0];
		end else if (load) begin
			outValid_q <= dataPop;
			if (dataPop) begin
				outData_q <= egHead;
				outLast_q <= lastBeat;
				outKeep_q <= lastBeat ? lastKeep : `VPF_KEEP_ALL;
				outLen_q <= curLen_q;
				outFirst_q <= first_q;
				first_q <= 1'b0;
				remain_q <= remain_q - 16'h0008;
				atHdr_q <= lastBeat;
			end
		end
	end
	assign egressValid = outValid_q;
	assign egressLast = outLast_q;
	assign egressData = outData_q;
	assign egressKeep = outKeep_q;
	assign egressLength = outLen_q;

	// ==========================================================
	// Drained flag
	logic drained_q;
	always_ff @(posedge clock) begin
		drained_q <= reset ? 1'b1 : (!memHas && inCount == 11'h000 && egCount == 11'h000 && !pendValid_q);
	end
	assign per_port_drained_flag = drained_q;

	// ==========================================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	sequence hdrIn;
		inFifoValid && !pendValid_q && !inPkt_q;
	endsequence
	sequence dataNext;
		##1 (pendValid_q && inFifoValid);
	endsequence
	sequence trainEnd;
		trainCount_q == 10'(`VPF_TRAIN_CYCLES - 1) && !coreRst;
	endsequence

	keep_full_a: assert property (egressValid && !egressLast |-> egressKeep == 8'hff)
		else $error("partial byte enables on a middle beat");
	first_len_a: assert property (dataPop && first_q && !outRst |=> egressValid && egressLength == curLen_q)
		else $error("length missing on first beat");
	egress_hold_a: assert property (!outEdge && !outRst |=> $stable({egressValid, egressLast, egressData}))
		else $error("egress output moved between reader edges");
	ingress_edge_a: assert property (inFifoValid && !pendValid_q |-> inEdge && inValidS)
		else $error("ingress push without a writer edge");
	region_bound_a: assert property (wGo |-> wrPtr_q >= region_base_bound && wrPtr_q <= region_top_bound)
		else $error("store write outside the region");
	wr_burst_a: assert property (wState_q == MOVE_RUN |-> wBeats_q <= ingress_burst_length)
		else $error("write burst longer than its cap");
	rd_burst_a: assert property (rState_q == MOVE_RUN |-> rBeats_q <= egress_burst_length)
		else $error("read burst longer than its cap");
	train_done_a: assert property (trainEnd ##1 !coreRst |=> memory_training_finished)
		else $error("training flag late");
	drained_a: assert property (memHas |=> !per_port_drained_flag)
		else $error("drained while the store holds words");
	header_data_a: assert property (hdrIn |-> dataNext)
		else $error("first beat did not follow its control word");
endmodule: vpf_port_top

// ==== core/vpf_preview_fifo.sv ====
// Preview FIFO, 64 bits by 1024 entries, with valid and ready on both sides
`timescale 1ns/1ns
`include "vpf_consts.svh"
module vpf_preview_fifo (
	input wire logic clock, // Core clock
	input wire logic reset, // Synchronous reset, active high
	input wire vpf_pkg::vpf_word_type inData, // Word to store
	input wire logic inValid, // Word offered
	output logic inReady, // Room for a word
	output vpf_pkg::vpf_word_type outData, // Oldest word
	output logic outValid, // Oldest word present
	input wire logic outReady, // Oldest word taken
	output logic [`VPF_FIFO_CNT_W-1:0] count // Words held
);
	import vpf_pkg::*;
	vpf_word_type store [0:`VPF_FIFO_DEPTH-1];
	logic [`VPF_FIFO_ADDR_W-1:0] wrPtr_q;
	logic [`VPF_FIFO_ADDR_W-1:0] rdPtr_q;
	logic [`VPF_FIFO_CNT_W-1:0] count_q;
	logic [`VPF_FIFO_CNT_W-1:0] count_d;
	logic push;
	logic pop;

	// ==========================================================
	// Flags and handshakes
	assign inReady = count_q != `VPF_FIFO_DEPTH;
	assign outValid = count_q != 11'h000;
	assign outData = store[rdPtr_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign count_d = count_q + {10'h000, push} - {10'h000, pop};
	assign count = count_q;

	// Storage has no reset, so it maps onto block memory
	always_ff @(posedge clock) begin
		if (push) begin
			store[wrPtr_q] <= inData;
		end
	end

	// Pointers wrap naturally at the power-of-two depth
	always_ff @(posedge clock) begin
		if (reset) begin
			wrPtr_q <= 10'h000;
			rdPtr_q <= 10'h000;
			count_q <= 11'h000;
		end else begin
			wrPtr_q <= wrPtr_q + {9'h000, push};
			rdPtr_q <= rdPtr_q + {9'h000, pop};
			count_q <= count_d;
		end
	end
endmodule: vpf_preview_fifo

// ==== sim/packetized_virtual_fifo_ports_test.sv ====
// Self-checking bench for one packet virtual FIFO port
`timescale 1ns/1ns
module packetized_virtual_fifo_ports_test;
	import vpf_pkg::*;
	logic clock, reset, ingressClock, egressClock, stallMode;
	logic ingressValid, ingressLast, ingressReady, ingress_port_reset_low;
	logic egressReady, egressValid, egressLast, egress_port_reset_low;
	vpf_word_type ingressData, egressData;
	logic [15:0] ingressLength, egressLength;
	logic [7:0] egressKeep;
	logic [11:0] region_base_bound, region_top_bound;
	logic [8:0] ingress_burst_length, egress_burst_length;
	logic reference_clock_pos, reference_clock_neg, memory_core_reset, fabric_shim_reset_low;
	logic memory_user_clock, memory_user_reset, memory_training_finished, per_port_drained_flag;
	int err_count = 0;
	int num_checks = 0;
	int n;
	logic prev;
	logic [47:0] expQ[$]; // Expected packets: length, tag
	int lens[6] = '{61, 8, 1, 130, 2048, 67};

	vpf_port_top DUT (.clock, .reset, .ingressClock, .ingressValid, .ingressLast, .ingressData, .ingressLength,
		.ingressReady, .ingress_port_reset_low, .egressClock, .egressReady, .egressValid, .egressLast, .egressData,
		.egressKeep, .egressLength, .egress_port_reset_low, .region_base_bound, .region_top_bound,
		.ingress_burst_length, .egress_burst_length, .reference_clock_pos, .reference_clock_neg,
		.memory_core_reset, .memory_user_clock, .memory_user_reset, .memory_training_finished,
		.per_port_drained_flag, .fabric_shim_reset_low);

	vpf_stream_partner partner (.ingressClock, .egressClock, .stallMode, .ingressValid, .ingressLast, .ingressData,
		.ingressLength, .ingressReady, .egressValid, .egressLast, .egressData, .egressKeep, .egressLength,
		.egressReady);

	// ==========
	// Clocks: core, two stream clocks of equal 48 ns period offset in phase, reference pair
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		ingressClock = 1'b0;
		#7;
		forever #24 ingressClock = ~ingressClock;
	end
	initial begin
		egressClock = 1'b0;
		#13;
		forever #24 egressClock = ~egressClock;
	end
	// Uneven halves give a 5 ns period at this time resolution
	initial begin
		forever begin
			reference_clock_pos = 1'b1;
			reference_clock_neg = 1'b0;
			#2;
			reference_clock_pos = 1'b0;
			reference_clock_neg = 1'b1;
			#3;
		end
	end

	// ==========
	// Tasks
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask: check

	task automatic cycles(input int k);
		repeat (k) @(posedge clock);
	endtask: cycles

	// Bounded wait for a level, then compare
	task automatic wait_cond(ref logic sig, input logic lvl, input int lim, input string what);
		int k;
		k = 0;
		while (sig !== lvl && k < lim) begin
			@(posedge clock);
			k++;
		end
		check(what, sig, lvl);
	endtask: wait_cond

	task automatic send(input int len, input logic [31:0] tag);
		expQ.push_back({16'(len), tag});
		partner.send_packet(len, tag);
	endtask: send

	// Every beat of every expected packet is compared in order
	task automatic drain(input int lim);
		int nb;
		int r;
		int k;
		logic [88:0] b;
		logic [47:0] e;
		k = 0;
		while (expQ.size() > 0) begin
			e = expQ.pop_front();
			nb = (e[47:32] + 7) / 8;
			r = (e[34:32] == 3'h0) ? 8 : e[34:32];
			for (int i = 0; i < nb; i++) begin
				while (partner.rxQ.size() == 0 && k < lim) begin
					@(posedge clock);
					k++;
				end
				if (partner.rxQ.size() == 0) begin
					check("beatArrived", 1'b0, 1'b1);
					return;
				end
				b = partner.rxQ.pop_front();
				check("data", b[63:0], {e[31:0], 32'(i)});
				check("length", b[79:64], e[47:32]);
				check("keep", b[87:80], (i == nb - 1) ? (8'hff >> (8 - r)) : 8'hff);
				check("last", b[88], i == nb - 1);
			end
		end
		wait_cond(per_port_drained_flag, 1'b1, 500, "drained");
	endtask: drain

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask: summarize

	// ==========
	// Watchdog well beyond the expected run of about 40 us
	initial begin
		#300000;
		err_count++;
		$display("timeout");
		summarize();
	end

	// ==========
	// Main sequence
	initial begin
		reset = 1'b1;
		stallMode = 1'b0;
		ingress_port_reset_low = 1'b1;
		egress_port_reset_low = 1'b1;
		region_base_bound = 12'h020;
		region_top_bound = 12'h03f;
		ingress_burst_length = 9'h100;
		egress_burst_length = 9'h100;
		memory_core_reset = 1'b0;
		fabric_shim_reset_low = 1'b1;
		cycles(2);
		check("drainedInReset", per_port_drained_flag, 1'b1);
		check("trainingInReset", memory_training_finished, 1'b0);
		check("userResetInReset", memory_user_reset, 1'b1);
		reset <= 1'b0;
		wait_cond(memory_training_finished, 1'b1, 1100, "training");
		cycles(2);
		check("userReset", memory_user_reset, 1'b0);
		n = 0;
		prev = memory_user_clock;
		repeat (40) begin
			@(posedge clock);
			if (memory_user_clock !== prev) n++;
			prev = memory_user_clock;
		end
		check("userClockMoves", n > 10, 1'b1);
		// Short packet under a long burst cap leaves only through the flush timeout
		send(64, 32'h1);
		partner.release_lines();
		cycles(4);
		check("drainedBusy", per_port_drained_flag, 1'b0);
		drain(2000);
		// Small bursts, small wrapping region, stalling reader, back-to-back packets
		@(posedge clock);
		stallMode <= 1'b1;
		ingress_burst_length <= 9'h004;
		egress_burst_length <= 9'h003;
		cycles(2);
		foreach (lens[i]) send(lens[i], 32'(16 + i));
		partner.release_lines();
		drain(20000);
		// Shim reset only once the port is drained; store and core survive it
		check("drainedBeforeShim", per_port_drained_flag, 1'b1);
		@(posedge clock);
		fabric_shim_reset_low <= 1'b0;
		cycles(10);
		check("trainingDuringShim", memory_training_finished, 1'b1);
		fabric_shim_reset_low <= 1'b1;
		cycles(4);
		send(24, 32'h30);
		partner.release_lines();
		drain(3000);
		// Port resets act on their own side only
		@(posedge clock);
		ingress_port_reset_low <= 1'b0;
		cycles(30);
		check("readyInIngressReset", ingressReady, 1'b0);
		ingress_port_reset_low <= 1'b1;
		egress_port_reset_low <= 1'b0;
		wait_cond(ingressReady, 1'b1, 60, "readyInEgressReset");
		check("validInEgressReset", egressValid, 1'b0);
		egress_port_reset_low <= 1'b1;
		cycles(30);
		send(16, 32'h40);
		partner.release_lines();
		drain(3000);
		// Core reset restarts calibration
		@(posedge clock);
		memory_core_reset <= 1'b1;
		cycles(8);
		check("trainingInCoreReset", memory_training_finished, 1'b0);
		check("userResetInCoreReset", memory_user_reset, 1'b1);
		memory_core_reset <= 1'b0;
		wait_cond(memory_training_finished, 1'b1, 1100, "retraining");
		send(40, 32'h50);
		partner.release_lines();
		drain(3000);
		summarize();
	end
endmodule: packetized_virtual_fifo_ports_test

// ==== sim/vpf_stream_partner.sv ====
// Stream partner model: the writer and the reader facing one FIFO port
`timescale 1ns/1ns
module vpf_stream_partner (
	input wire logic ingressClock, // Writer clock
	input wire logic egressClock, // Reader clock
	input wire logic stallMode, // Reader takes every other edge only
	output logic ingressValid, // Beat valid
	output logic ingressLast, // End of packet
	output vpf_pkg::vpf_word_type ingressData, // Beat data
	output logic [15:0] ingressLength, // Packet length in bytes
	input wire logic ingressReady, // Room for a beat
	input wire logic egressValid, // Beat valid
	input wire logic egressLast, // End of packet
	input wire vpf_pkg::vpf_word_type egressData, // Beat data
	input wire logic [7:0] egressKeep, // Byte enables
	input wire logic [15:0] egressLength, // Packet length in bytes
	output logic egressReady // Reader takes a beat
);
	import vpf_pkg::*;
	logic [88:0] rxQ[$]; // Received beats: last, keep, length, data

	// ==========
	// Writer
	initial begin
		ingressValid = 1'b0;
		ingressLast = 1'b0;
		ingressData = '0;
		ingressLength = '0;
		egressReady = 1'b0;
	end

	// Each beat stands until an edge finds ready high; length rides every beat
	task automatic send_packet(input int len, input logic [31:0] tag);
		int nb;
		int i;
		nb = (len + 7) / 8;
		i = 0;
		if (ingressValid !== 1'b1) @(posedge ingressClock);
		while (i < nb) begin
			ingressValid <= 1'b1;
			ingressData <= {tag, 32'(i)};
			ingressLast <= (i == nb - 1);
			ingressLength <= 16'(len);
			@(posedge ingressClock);
			if (ingressReady === 1'b1) i++;
		end
	endtask: send_packet

	// Released lines show the inverse, so a stale beat cannot pass for a fresh one
	task automatic release_lines();
		ingressValid <= 1'b0;
		ingressLast <= ~ingressLast;
		ingressData <= ~ingressData;
		ingressLength <= ~ingressLength;
	endtask: release_lines

	// ==========
	// Reader
	always @(posedge egressClock) begin
		if (egressValid === 1'b1 && egressReady === 1'b1) rxQ.push_back({egressLast, egressKeep, egressLength, egressData});
		egressReady <= stallMode ? ~egressReady : 1'b1;
	end
endmodule: vpf_stream_partner
